/* File: hw/timer_zero.sv */
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps

// Overview of operation
// R1: count register is 8 bits, read and write
// R2: 8-bit prescaler with software-set ratio
// R3: clock_source_select zero selects timer mode
// R4: timer mode counts every instruction cycle
// R5: count write suppresses counting for two cycles
// R6: clock_source_select one counts external pin edges
// R7: source_edge_select zero rising, one falling edge
// R8: prescaler serves timer or watchdog, never both
// R9: prescaler_assign zero timer, one watchdog
// R10: prescaler count hidden from software
// R11: timer ratios 1:2 through 1:256, powers two
// R12: count wraps from FF to 00
module timer_zero (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       EXT_COUNT_PIN,
  input  wire logic       WATCHDOG_TICK,
  output logic            WATCHDOG_TIMEOUT,
  output logic            OVERFLOW
);

  tmr_pkg::bus_req_s req;
  tmr_pkg::config_s  cfg_r;
  tmr_pkg::config_s  cfg_nxt;
  logic [7:0]        count_r;
  logic [7:0]        count_nxt;
  logic [1:0]        inhibit_r;
  logic [1:0]        inhibit_nxt;
  logic              pin_prev_r;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;
  logic              ovf_r;
  logic              wdt_out_r;
  logic              pre_pulse;

  wire               wr_count;
  wire               wr_config;
  wire               rd_count;
  wire               rd_config;
  wire               rd_status;
  wire               pin_rise;
  wire               pin_fall;
  wire               ext_edge;
  wire               timer_src;
  wire               pre_tick;
  wire               pre_clr;
  wire               owner_change;
  wire               inc_event;
  wire               inc_en;
  wire               wrap;
  wire [7:0]         config_byte;
  wire [7:0]         status_byte;
  wire [7:0]         rd_val;

  // bundle the register port
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // address decode; unmapped writes are dropped, unmapped reads give zero
  assign wr_count  = req.wr && (req.addr == tmr_pkg::COUNT_OFS);   // see R1
  assign wr_config = req.wr && (req.addr == tmr_pkg::CONFIG_OFS);
  assign rd_count  = req.rd && (req.addr == tmr_pkg::COUNT_OFS);   // see R1
  assign rd_config = req.rd && (req.addr == tmr_pkg::CONFIG_OFS);
  assign rd_status = req.rd && (req.addr == tmr_pkg::STATUS_OFS);

  // pin is synchronous already, so one stage of history finds edges
  assign pin_rise  = EXT_COUNT_PIN && !pin_prev_r;
  assign pin_fall  = !EXT_COUNT_PIN && pin_prev_r;
  assign ext_edge  = cfg_r.source_edge_select ? pin_fall : pin_rise; // see R7

  // timer mode ticks every cycle, counter mode on the chosen edge
  assign timer_src = cfg_r.clock_source_select ? ext_edge : 1'b1;  // see R3
                                                                   // see R6
  // one prescaler, fed by whichever side owns it
  assign pre_tick  = cfg_r.prescaler_assign ? WATCHDOG_TICK : timer_src; // see R9

  // restart the divider on an owner change or a count write it serves,
  // so no partial count leaks between owners
  assign owner_change = wr_config &&
                        (req.wdata[tmr_pkg::PA_BIT] != cfg_r.prescaler_assign);
  assign pre_clr      = owner_change ||
                        (wr_count && !cfg_r.prescaler_assign);     // see R8

  prescaler_div u_prescaler (
    .clk   (CLK),
    .rst   (RST),
    .clr   (pre_clr),
    .tick  (pre_tick),
    .ratio (cfg_r.ratio),
    .pulse (pre_pulse)
  );

  // without the prescaler the timer runs 1:1
  assign inc_event = cfg_r.prescaler_assign ? timer_src : pre_pulse; // see R8
  assign inc_en    = inc_event && (inhibit_r == tmr_pkg::INHIBIT_NONE); // see R5
  assign wrap      = inc_en && !wr_count && (count_r == 8'hFF);    // see R12

  // a write wins over an increment in the same cycle
  assign count_nxt = wr_count ? req.wdata :
                     inc_en   ? 8'(count_r + 8'h01) : count_r;     // see R4
                                                                   // see R12
  // two-cycle hold after any count write
  assign inhibit_nxt = wr_count ? tmr_pkg::INHIBIT_CYCLES :
                       (inhibit_r != tmr_pkg::INHIBIT_NONE) ?
                       2'(inhibit_r - 2'h1) : inhibit_r;           // see R5

  assign cfg_nxt = wr_config ? tmr_pkg::cfg_from_byte(req.wdata) : cfg_r; // see R2

  // read views; the prescaler count never appears here
  assign config_byte = {2'h0, cfg_r};
  assign status_byte = {4'h0, pin_prev_r, cfg_r.prescaler_assign, inhibit_r}; // see R10
  assign rd_val      = rd_count  ? count_r     :
                       rd_config ? config_byte :
                       rd_status ? status_byte : 8'h00;
  // read data lives for exactly the cycle after the strobe
  assign rdata_nxt   = req.rd ? rd_val : tmr_pkg::RDATA_RST;

  // count and hold state
  always_ff @(posedge CLK) begin
    if (RST) begin
      count_r   <= tmr_pkg::COUNT_RST;
      inhibit_r <= tmr_pkg::INHIBIT_NONE;
    end else begin
      count_r   <= count_nxt;
      inhibit_r <= inhibit_nxt;
    end
  end

  // configuration and edge history
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_r      <= tmr_pkg::cfg_from_byte(tmr_pkg::CONFIG_RST);
      pin_prev_r <= 1'b0;
    end else begin
      cfg_r      <= cfg_nxt;
      pin_prev_r <= EXT_COUNT_PIN;
    end
  end

  // registered outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_r   <= tmr_pkg::RDATA_RST;
      ovf_r     <= 1'b0;
      wdt_out_r <= 1'b0;
    end else begin
      rdata_r   <= rdata_nxt;
      ovf_r     <= wrap;
      wdt_out_r <= cfg_r.prescaler_assign && pre_pulse;            // see R9
    end
  end

  assign RDATA            = rdata_r;
  assign OVERFLOW         = ovf_r;
  assign WATCHDOG_TIMEOUT = wdt_out_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // a count write loads the exact byte
  property p_write_load;
    wr_count |=> count_r == $past(req.wdata);
  endproperty
  a_write_load: assert property (p_write_load)                     // see R1
    else $error("count write not loaded");

  // a count read returns the count one cycle later
  property p_read_count;
    rd_count |=> RDATA == $past(count_r);
  endproperty
  a_read_count: assert property (p_read_count)                     // see R1
    else $error("count read data wrong");

  // timer mode without prescaler adds one per cycle
  property p_timer_tick;
    (!wr_count && inhibit_r == tmr_pkg::INHIBIT_NONE &&
     !cfg_r.clock_source_select && cfg_r.prescaler_assign)
      |=> count_r == 8'($past(count_r) + 8'h01);
  endproperty
  a_timer_tick: assert property (p_timer_tick)                     // see R4
    else $error("timer did not step");

  // write, two held cycles, then counting resumes
  sequence s_timer_load;
    wr_count && !cfg_r.clock_source_select && cfg_r.prescaler_assign;
  endsequence
  sequence s_no_write;
    !WR [*3];
  endsequence
  property p_write_inhibit;
    s_timer_load ##1 s_no_write |=> count_r == 8'($past(count_r, 3) + 8'h01);
  endproperty
  a_write_inhibit: assert property (p_write_inhibit)               // see R5
    else $error("increment not held for two cycles");

  // nothing moves while the hold is active
  property p_inhibit_hold;
    (inhibit_r != tmr_pkg::INHIBIT_NONE && !wr_count) |=> $stable(count_r);
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold)                 // see R5
    else $error("count moved during hold");

  // counter mode steps on a selected edge
  property p_counter_edge;
    (cfg_r.clock_source_select && cfg_r.prescaler_assign && ext_edge &&
     !wr_count && inhibit_r == tmr_pkg::INHIBIT_NONE)
      |=> count_r == 8'($past(count_r) + 8'h01);
  endproperty
  a_counter_edge: assert property (p_counter_edge)                 // see R6
    else $error("counter missed an edge");

  // rising selected: a falling edge leaves the count alone
  property p_edge_select;
    (cfg_r.clock_source_select && !cfg_r.source_edge_select &&
     pin_prev_r && !EXT_COUNT_PIN && !wr_count) |=> $stable(count_r);
  endproperty
  a_edge_select: assert property (p_edge_select)                   // see R7
    else $error("counted on the wrong edge");

  // prescaler owned by the timer never reaches the watchdog
  property p_exclusive;
    (!cfg_r.prescaler_assign && !wr_config) |=> !WATCHDOG_TIMEOUT;
  endproperty
  a_exclusive: assert property (p_exclusive)                       // see R8
    else $error("watchdog got the timer prescaler");

  // owned by the watchdog, its divided tick comes out
  property p_route_wdt;
    (cfg_r.prescaler_assign && pre_pulse) |=> WATCHDOG_TIMEOUT;
  endproperty
  a_route_wdt: assert property (p_route_wdt)                       // see R9
    else $error("watchdog tick not routed");

  // ratio 1:2 in timer mode gives two steps in four cycles
  property p_div_two;
    (!cfg_r.clock_source_select && !cfg_r.prescaler_assign &&
     cfg_r.ratio == 3'h0 && inhibit_r == tmr_pkg::INHIBIT_NONE && !WR) [*5]
      |-> count_r == 8'($past(count_r, 4) + 8'h02);
  endproperty
  a_div_two: assert property (p_div_two)                           // see R11
    else $error("1:2 ratio wrong");

  // FF steps to 00 and flags the overflow
  property p_wrap;
    (count_r == 8'hFF && inc_en && !wr_count)
      |=> (count_r == 8'h00) && OVERFLOW;
  endproperty
  a_wrap: assert property (p_wrap)                                 // see R12
    else $error("count did not wrap");

  // configuration write takes effect next cycle
  property p_config_write;
    wr_config |=> cfg_r == tmr_pkg::cfg_from_byte($past(req.wdata));
  endproperty
  a_config_write: assert property (p_config_write)                 // see R2
    else $error("configuration not stored");

endmodule

/* File: inc/tmr_pkg.sv */
package tmr_pkg;

  // register offsets on the plain register port (byte addresses)
  localparam logic [3:0] COUNT_OFS      = 4'h0;
  localparam logic [3:0] CONFIG_OFS     = 4'h4;
  localparam logic [3:0] STATUS_OFS     = 4'h8;

  // configuration field positions
  localparam int         CSS_BIT        = 5;
  localparam int         SES_BIT        = 4;
  localparam int         PA_BIT         = 3;
  localparam int         RATIO_LSB      = 0;
  localparam int         RATIO_W        = 3;

  // status field positions
  localparam int         ST_INHIBIT_LSB = 0;
  localparam int         ST_OWNER_BIT   = 2;
  localparam int         ST_PIN_BIT     = 3;

  // values after reset
  localparam logic [7:0] COUNT_RST      = 8'h00;
  localparam logic [7:0] CONFIG_RST     = 8'h3F;
  localparam logic [7:0] PRESCALE_RST   = 8'h00;
  localparam logic [7:0] RDATA_RST      = 8'h00;

  // cycles of suppressed counting after a count write
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [1:0] INHIBIT_NONE   = 2'h0;

  // configuration bits 5..0, bits 7..6 read as zero
  typedef struct packed {
    logic               clock_source_select;
    logic               source_edge_select;
    logic               prescaler_assign;
    logic [RATIO_W-1:0] ratio;
  } config_s;

  // one request on the register port
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  // mask of low prescaler bits: ratio n divides by 2^(n+1)
  function automatic logic [7:0] ratio_mask(input logic [RATIO_W-1:0] r);
    ratio_mask = 8'hFF >> (3'h7 - r);
  endfunction

  // configuration byte to its field view
  function automatic config_s cfg_from_byte(input logic [7:0] b);
    cfg_from_byte = config_s'(b[5:0]);
  endfunction

endpackage

/* File: hw/prescaler_div.sv */
`timescale 1ns/10ps

module prescaler_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire logic [2:0] ratio,
  output logic            pulse
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  wire  [7:0] mask;

  // the count is hidden: no port reads or loads it
  assign mask    = tmr_pkg::ratio_mask(ratio);
  // a clear swallows the tick so the new owner starts from zero
  assign pulse   = tick && !clr && ((cnt_r & mask) == mask);      // see R11
  assign cnt_nxt = clr  ? tmr_pkg::PRESCALE_RST :
                   tick ? 8'(cnt_r + 8'h01) : cnt_r;

  // free-running divider, low bits select the ratio
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= tmr_pkg::PRESCALE_RST;
    end else begin
      cnt_r <= cnt_nxt;                                           // see R2
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_div_clear;
    clr |=> cnt_r == tmr_pkg::PRESCALE_RST;
  endproperty
  a_div_clear: assert property (p_div_clear)                       // see R2
    else $error("prescaler not cleared");

endmodule

/* File: testbench/pin_source.sv */
`timescale 1ns/10ps

// external pulse source on the count pin; low after a burst, high after a rise
module pin_source (
  input  wire logic CLK,
  output logic      pin
);
  initial pin = 1'b0;

  // n whole pulses, each level held for half cycles; small half is prompt, large is slow
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      pin <= 1'b1;
      repeat (half) @(posedge CLK);
      pin <= 1'b0;
      repeat (half) @(posedge CLK);
    end
  endtask

  // one lone rising edge, pin left high so rises and falls differ in number
  task automatic rise();
    pin <= 1'b1;
    @(posedge CLK);
  endtask
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/10ps

module testbench;
  logic       clk;
  logic       rst;
  logic       wr;
  logic       rd;
  logic       tick;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] exp_s;
  logic [7:0] exp_r;
  logic       rdp_r;
  logic       live;
  logic [7:0] rdata;
  logic       pin;
  logic       ovf;
  logic       wto;
  int         num_errors;
  int         comparisons;
  int         cycles;
  int         ovf_cnt;
  int         wto_cnt;
  int         d;

  timer_zero dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .EXT_COUNT_PIN(pin), .WATCHDOG_TICK(tick), .WATCHDOG_TIMEOUT(wto),
    .OVERFLOW(ovf));
  pin_source src (.CLK(clk), .pin(pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic close_out();
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // one bus cycle; every input set once so strobes never toggle twice in a step
  task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] v,
                     input logic t);
    wr    <= w;
    rd    <= r;
    addr  <= a;
    wdata <= v;
    exp_s <= v;
    tick  <= t;
    @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    cyc(1'b1, 1'b0, a, v, 1'b0);
  endtask

  // expected value rides along and is compared in the following cycle
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    cyc(1'b0, 1'b1, a, e, 1'b0);
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
  endtask

  // read pipeline and hang guard; ceiling well above the ~1170 cycles needed
  always @(posedge clk) begin
    rdp_r <= rd;
    exp_r <= exp_s;
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      close_out();
    end
  end

  // read data must stand one cycle only, zero otherwise; pulses are counted here
  always @(negedge clk) begin
    if (live) check(rdata, rdp_r ? exp_r : 8'h00);
    if (ovf === 1'b1) ovf_cnt++;
    if (wto === 1'b1) wto_cnt++;
  end

  initial begin
    {rst, wr, rd, tick, rdp_r, live} = 6'h20;
    {addr, wdata, exp_s, exp_r} = 28'h0;
    repeat (4) @(posedge clk);
    rst  <= 1'b0;
    live <= 1'b1;
    @(posedge clk);
    // reset values, unmapped and read-only places
    rd_reg(tmr_pkg::COUNT_OFS, 8'h00);
    rd_reg(tmr_pkg::CONFIG_OFS, 8'h3F);
    rd_reg(4'hC, 8'h00);
    wr_reg(tmr_pkg::STATUS_OFS, 8'hFF);
    rd_reg(tmr_pkg::STATUS_OFS, 8'h04);
    wr_reg(tmr_pkg::CONFIG_OFS, 8'hC8);
    rd_reg(tmr_pkg::CONFIG_OFS, 8'h08);
    // write inhibit, then every-cycle steps across the wrap
    wr_reg(tmr_pkg::COUNT_OFS, 8'hFE);
    rd_reg(tmr_pkg::COUNT_OFS, 8'hFE);
    rd_reg(tmr_pkg::COUNT_OFS, 8'hFE);
    rd_reg(tmr_pkg::COUNT_OFS, 8'hFE);
    rd_reg(tmr_pkg::COUNT_OFS, 8'hFF);
    rd_reg(tmr_pkg::COUNT_OFS, 8'h00);
    idle(2);
    check(8'(ovf_cnt), 8'h01);
    wr_reg(4'hC, 8'h55);
    rd_reg(tmr_pkg::CONFIG_OFS, 8'h08);
    // watchdog owns the prescaler at 1:2, then loses it
    repeat (8) begin
      cyc(1'b0, 1'b0, 4'h0, 8'h00, 1'b1);
      idle(1);
    end
    idle(2);
    check(8'(wto_cnt), 8'h04);
    wr_reg(tmr_pkg::CONFIG_OFS, 8'h00);
    repeat (8) begin
      cyc(1'b0, 1'b0, 4'h0, 8'h00, 1'b1);
      idle(1);
    end
    idle(2);
    check(8'(wto_cnt), 8'h04);
    // every ratio: read just after the second step; at 1:2 the first pulse falls in the hold
    for (int r = 0; r < 8; r++) begin
      d = 2 << r;
      wr_reg(tmr_pkg::CONFIG_OFS, {5'h00, 3'(r)});
      wr_reg(tmr_pkg::COUNT_OFS, 8'h00);
      idle(2 * d + 2);
      rd_reg(tmr_pkg::COUNT_OFS, 8'h02);
    end
    // counter mode: rising-edge burst plus a lone rise, then falling burst from high
    wr_reg(tmr_pkg::CONFIG_OFS, 8'h28);
    wr_reg(tmr_pkg::COUNT_OFS, 8'h00);
    idle(3);
    src.pulses(5, 1);
    src.rise();
    idle(2);
    rd_reg(tmr_pkg::COUNT_OFS, 8'h06);
    wr_reg(tmr_pkg::CONFIG_OFS, 8'h38);
    wr_reg(tmr_pkg::COUNT_OFS, 8'h00);
    idle(3);
    src.pulses(3, 4);
    idle(2);
    rd_reg(tmr_pkg::COUNT_OFS, 8'h03);
    idle(2);
    close_out();
  end
endmodule
